// file: logic/ppp_consts.svh
`ifndef PPP_CONSTS_SVH
`define PPP_CONSTS_SVH

// Register offsets within the port window
`define PPP_OFS_DATA        2'h0
`define PPP_OFS_STATUS      2'h1
`define PPP_OFS_CONTROL     2'h2

// Status bit positions
`define PPP_ST_BUSY         7
`define PPP_ST_ACK          6
`define PPP_ST_PAPER_END    5
`define PPP_ST_SELECTED     4
`define PPP_ST_ERROR_N      3

// Control bit positions
`define PPP_CT_DIR_IN       5
`define PPP_CT_IRQ_EN       4
`define PPP_CT_SELECT_IN    3
`define PPP_CT_INIT_N       2
`define PPP_CT_AUTO_LF      1
`define PPP_CT_STROBE       0

// Writable control bits and their reset value (init asserted, all else idle)
`define PPP_CT_MASK         8'h3F
`define PPP_CT_RESET        8'h00
`define PPP_DATA_RESET      8'h00

// Peripheral timing, printed figures in nanoseconds
`define PPP_CLK_PERIOD_NS   5
`define PPP_STROBE_MIN_NS   500
`define PPP_SETUP_MIN_NS    500
`define PPP_INIT_MIN_NS     50000
`define PPP_ACK_TYP_NS      5000

// Cycle counts, least times rounded up
`define PPP_CYC(ns)         (((ns) + `PPP_CLK_PERIOD_NS - 1) / `PPP_CLK_PERIOD_NS)

`endif

// file: logic/ppp_pkg.sv
package ppp_pkg;

	// Host command as it enters the port
	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [1:0] addr;
		logic [7:0] wdata;
	} ppp_req_t;

	// Sampled peripheral inputs
	typedef struct packed
	{
		logic busy;
		logic ack_n;
		logic paper_end;
		logic selected;
		logic error_n;
	} ppp_pins_t;

	// Data-path word handed toward the pins
	typedef struct packed
	{
		logic [7:0] data;
	} ppp_word_t;

	// Strobe sequencer states
	typedef enum logic [1:0]
	{
		PPP_IDLE  = 2'b00,
		PPP_SETUP = 2'b01,
		PPP_PULSE = 2'b10,
		PPP_HOLD  = 2'b11
	} ppp_state_t;

endpackage

// file: logic/ppp_port.sv
// What this block does
// - Offset zero writes data latch, reads it back, or the data lines in input mode
// - Offset one reads sampled printer status
// - Offset two writes control, reads back all but bit 5
// - Status bit 7 shows peripheral busy
// - Status bit 6 shows live acknowledge
// - Status bit 5 shows paper end
// - Status bit 4 shows peripheral selected
// - Status bit 3 low on error
// - Control bit 5 turns data lines around
// - Control bit 4 enables acknowledge-rise interrupt
// - Control bit 3 drives select-in
// - Control bit 2 zero asserts initialise
// - Control bit 1 drives auto line feed
// - Control bit 0 strobe, setup, hold timing
// - Eight parallel data bits to peripheral
`timescale 1ns/1ps
`include "ppp_consts.svh"

module ppp_port
	import ppp_pkg::*;
#(
	parameter int STROBE_NS = `PPP_STROBE_MIN_NS,
	parameter int SETUP_NS  = `PPP_SETUP_MIN_NS
)
(
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// Host register port
	input  wire logic       WR,
	input  wire logic       RD,
	input  wire logic [1:0] ADDR,
	input  wire logic [7:0] WDATA,
	output logic      [7:0] RDATA,
	// Data path handshake toward the pins
	output logic            DATA_READY,
	// Interrupt request
	output logic            IRQ,
	// Peripheral data lines, two-way
	input  wire logic [7:0] PD_IN,
	output logic      [7:0] PD_OUT,
	output logic            PD_OE,
	// Peripheral control outputs, true level
	output logic            STROBE,
	output logic            AUTO_LF,
	output logic            INIT_N,
	output logic            SELECT_IN,
	// Peripheral status inputs, pin levels
	input  wire logic       BUSY,
	input  wire logic       ACK_N,
	input  wire logic       PAPER_END,
	input  wire logic       SELECTED,
	input  wire logic       ERROR_N
);

	localparam int STROBE_CYC = `PPP_CYC(STROBE_NS);
	localparam int SETUP_CYC  = `PPP_CYC(SETUP_NS);
	localparam int CW         = 16;

	// Elaboration check: refuse timing counts the phase timer cannot hold
	if (STROBE_CYC < 1 || SETUP_CYC < 1 || STROBE_CYC >= (1 << CW) ||
		SETUP_CYC >= (1 << CW))
	begin : g_bad_timing
		$error("ppp_port: timing counts out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	ppp_pins_t  pins_meta;                      // First stage, read only by second
	ppp_pins_t  pins;                           // Safe sampled pins
	logic [7:0] pd_meta;                        // First stage of data inputs
	logic [7:0] pd_sync;                        // Safe sampled data inputs
	ppp_req_t   req;                            // Host command bundle

	assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

	// Two flops on every pin input
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			pins_meta <= '{busy: 1'b0, ack_n: 1'b1, paper_end: 1'b0,
				selected: 1'b0, error_n: 1'b1};
			pins      <= '{busy: 1'b0, ack_n: 1'b1, paper_end: 1'b0,
				selected: 1'b0, error_n: 1'b1};
			pd_meta   <= 8'h00;
			pd_sync   <= 8'h00;
		end
		else
		begin
			pins_meta <= '{busy: BUSY, ack_n: ACK_N, paper_end: PAPER_END,
				selected: SELECTED, error_n: ERROR_N};
			pins      <= pins_meta;
			pd_meta   <= PD_IN;
			pd_sync   <= pd_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host registers

	logic [7:0] data_latch;                     // Output data latch
	logic [7:0] ctrl;                           // Control latch, bits 7:6 stay zero
	logic [7:0] status;                         // Assembled status byte
	logic       wr_data;                        // Host data write this cycle
	logic       wr_ctrl;                        // Host control write this cycle

	assign wr_data = req.wr && req.addr == `PPP_OFS_DATA;
	assign wr_ctrl = req.wr && req.addr == `PPP_OFS_CONTROL;

	// Data latch loads only when the buffer can take the word
	always_ff @(posedge CLK)
	begin
		if (RST)
			data_latch <= `PPP_DATA_RESET;
		else if (wr_data && DATA_READY)
			data_latch <= req.wdata;
	end

	// Control latch; unused high bits never store
	always_ff @(posedge CLK)
	begin
		if (RST)
			ctrl <= `PPP_CT_RESET;
		else if (wr_ctrl)
			ctrl <= req.wdata & `PPP_CT_MASK;
	end

	// Status byte from sampled pins, low bits zero
	always_comb
	begin
		status                    = 8'h00;
		status[`PPP_ST_BUSY]      = pins.busy;
		status[`PPP_ST_ACK]       = pins.ack_n;
		status[`PPP_ST_PAPER_END] = pins.paper_end;
		status[`PPP_ST_SELECTED]  = pins.selected;
		status[`PPP_ST_ERROR_N]   = pins.error_n;
	end

	// Registered read data, one cycle after RD
	always_ff @(posedge CLK)
	begin
		if (RST)
			RDATA <= 8'h00;
		else if (req.rd)
		begin
			case (req.addr)
				// Input mode shows the synchronised lines, else the data latch
				`PPP_OFS_DATA:    RDATA <= ctrl[`PPP_CT_DIR_IN] ? pd_sync : data_latch;
				`PPP_OFS_STATUS:  RDATA <= status;
				// Direction bit is write-only and reads as zero
				`PPP_OFS_CONTROL: RDATA <= ctrl & ~(8'h01 << `PPP_CT_DIR_IN);
				// Unmapped place reads as zero
				default:          RDATA <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Two-entry buffer between the data latch and the pins

	ppp_word_t  buf_mem [2];                    // Storage
	logic       wptr;                           // Write slot
	logic       rptr;                           // Read slot
	logic [1:0] count;                          // Words held
	logic       buf_valid;                      // Drain side has a word
	logic       buf_take;                       // Drain side accepts
	logic       push;                           // Fill side writes

	// Ready while a slot is free; valid while a word waits
	assign DATA_READY = count != 2'd2;
	assign buf_valid  = count != 2'd0;
	assign push       = wr_data && DATA_READY;

	// Push and pop with honest full and empty
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			wptr  <= 1'b0;
			rptr  <= 1'b0;
			count <= 2'd0;
		end
		else
		begin
			if (push)
			begin
				buf_mem[wptr] <= '{data: req.wdata};
				wptr          <= ~wptr;
			end
			if (buf_take)
				rptr <= ~rptr;
			// Push and pop in one cycle leave the count unchanged
			count <= count + {1'b0, push} - {1'b0, buf_take};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin word register; holds while the strobe sequencer is busy

	ppp_state_t state;                          // Strobe sequencer state
	ppp_state_t next_state;                     // Its next value
	logic [CW-1:0] tmr;                         // Phase timer
	logic       strobe_req;                     // Software strobe bit level
	logic       strobe_prev;                    // Strobe bit last IDLE cycle, zero while a word waits, one outside IDLE

	assign strobe_req = ctrl[`PPP_CT_STROBE];
	// Drain only when idle so pin data stays stable through a strobe
	assign buf_take   = buf_valid && state == PPP_IDLE;

	// Word presented on the eight data lines
	always_ff @(posedge CLK)
	begin
		if (RST)
			PD_OUT <= `PPP_DATA_RESET;
		else if (buf_take)
			PD_OUT <= buf_mem[rptr].data;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strobe sequencer: setup, pulse, hold

	// Next state
	always_comb
	begin
		next_state = state;
		case (state)
			// Start on a fresh strobe bit rise once the buffer is drained
			PPP_IDLE:  if (strobe_req && !strobe_prev && !buf_valid) next_state = PPP_SETUP;
			// Data settles on the lines before the pulse
			PPP_SETUP: if (tmr == 16'h0000) next_state = PPP_PULSE;
			// Pulse lasts the minimum and until software drops the bit
			PPP_PULSE: if (tmr == 16'h0000 && !strobe_req) next_state = PPP_HOLD;
			// Data stays put after the pulse
			PPP_HOLD:  if (tmr == 16'h0000) next_state = PPP_IDLE;
			default:   next_state = PPP_IDLE;
		endcase
	end

	// State, timer and edge memory
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state       <= PPP_IDLE;
			tmr         <= 16'h0000;
			strobe_prev <= 1'b0;
		end
		else
		begin
			state <= next_state;
			// Only a seen rising edge is consumed; an early one waits in IDLE
			if (state == PPP_IDLE && next_state == PPP_IDLE)
				strobe_prev <= strobe_req && buf_valid ? 1'b0 : strobe_req;
			else
				strobe_prev <= 1'b1;
			if (next_state != state)
			begin
				case (next_state)
					PPP_SETUP: tmr <= CW'(SETUP_CYC - 1);
					PPP_PULSE: tmr <= CW'(STROBE_CYC - 1);
					PPP_HOLD:  tmr <= CW'(SETUP_CYC - 1);
					default:   tmr <= 16'h0000;
				endcase
			end
			else if (tmr != 16'h0000)
				tmr <= tmr - 16'h0001;
		end
	end

	// Strobe pin high only in the pulse phase
	always_ff @(posedge CLK)
	begin
		if (RST)
			STROBE <= 1'b0;
		else
			STROBE <= next_state == PPP_PULSE;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control outputs and data direction

	// Registered control pins
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			AUTO_LF   <= 1'b0;
			INIT_N    <= 1'b0;
			SELECT_IN <= 1'b0;
			// Drive the data lines from reset, as a printer port
			PD_OE     <= 1'b1;
		end
		else
		begin
			AUTO_LF   <= ctrl[`PPP_CT_AUTO_LF];
			INIT_N    <= ctrl[`PPP_CT_INIT_N];
			SELECT_IN <= ctrl[`PPP_CT_SELECT_IN];
			PD_OE     <= ~ctrl[`PPP_CT_DIR_IN];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Acknowledge-rise interrupt

	logic ack_prev;                             // Acknowledge last cycle
	logic ack_rise;                             // Low-to-high edge seen
	logic stat_read;                            // Host reads status

	assign ack_rise  = pins.ack_n && !ack_prev;
	assign stat_read = req.rd && req.addr == `PPP_OFS_STATUS;

	// Edge detect on the synchronised line
	always_ff @(posedge CLK)
	begin
		if (RST)
			ack_prev <= 1'b1;
		else
			ack_prev <= pins.ack_n;
	end

	// Sticky request; a new edge wins over the clearing read
	always_ff @(posedge CLK)
	begin
		if (RST)
			IRQ <= 1'b0;
		else if (!ctrl[`PPP_CT_IRQ_EN])
			IRQ <= 1'b0;
		// An enabled rise sets the request
		else if (ack_rise)
			IRQ <= 1'b1;
		// Status read services the request
		else if (stat_read)
			IRQ <= 1'b0;
	end

endmodule

// file: tb/ppp_checker.sv
`timescale 1ns/1ps
module ppp_checker
#(
	parameter int STROBE_NS = 500,
	parameter int SETUP_NS  = 500
)
(
	// Host side
	input wire logic       CLK,
	input wire logic       RST,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic [7:0] RDATA,
	input wire logic       DATA_READY,
	input wire logic       IRQ,
	// Pin side
	input wire logic [7:0] PD_OUT,
	input wire logic       PD_OE,
	input wire logic       STROBE,
	input wire logic       AUTO_LF,
	input wire logic       INIT_N,
	input wire logic       SELECT_IN,
	input wire logic       ACK_N
);
	localparam int STB_C = (STROBE_NS + 4) / 5; // Least strobe cycles
	localparam int SET_C = (SETUP_NS + 4) / 5;  // Least setup cycles
	int hi_cnt; // Strobe high run
	int st_cnt; // Data still run
	int ak_cnt; // Acknowledge still run
	logic [7:0] pd_prev; // Data lines last edge
	logic       ak_prev; // Acknowledge last edge
	////////////////////////////////////////////////////////////////
	// Run counters for timing checks, cleared by reset
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			hi_cnt  <= 0;
			st_cnt  <= 0;
			ak_cnt  <= 0;
			pd_prev <= 8'h00;
			ak_prev <= 1'b1;
		end
		else
		begin
			hi_cnt  <= STROBE ? hi_cnt + 1 : 0;
			st_cnt  <= (PD_OUT != pd_prev) ? 0 : st_cnt + 1;
			ak_cnt  <= (ACK_N != ak_prev) ? 0 : ak_cnt + 1;
			pd_prev <= PD_OUT;
			ak_prev <= ACK_N;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	property p_st_zero; RD && ADDR == 2'h1 |=> RDATA[2:0] == 3'h0; endproperty
	a_st_zero: assert property (p_st_zero) else $error("status spare bits set");
	property p_ctl_rd; RD && ADDR == 2'h2 |=> RDATA[7:5] == 3'h0; endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control top bits set");
	property p_ctl_out;
		WR && ADDR == 2'h2 |-> ##2 {SELECT_IN, INIT_N, AUTO_LF} == $past(WDATA[3:1], 2);
	endproperty
	a_ctl_out: assert property (p_ctl_out) else $error("control pins wrong");
	property p_dir; WR && ADDR == 2'h2 |-> ##2 PD_OE == !$past(WDATA[5], 2); endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");
	property p_irq_off; WR && ADDR == 2'h2 && !WDATA[4] |-> ##2 !IRQ; endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked irq high");
	property p_irq_clr; RD && ADDR == 2'h1 && ak_cnt > 2 |=> !IRQ; endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
	property p_irq_rise; $rose(IRQ) |-> ACK_N && $past(ACK_N); endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq without ack rise");
	property p_setup; $rose(STROBE) |-> st_cnt >= SET_C - 1; endproperty
	a_setup: assert property (p_setup) else $error("data setup short");
	property p_pulse; $fell(STROBE) |-> hi_cnt >= STB_C; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe short");
	property p_hold; $fell(STROBE) |-> $stable(PD_OUT) [*8]; endproperty
	a_hold: assert property (p_hold) else $error("data hold short");
	c_strobe: cover property ($rose(STROBE));
	c_irq: cover property ($rose(IRQ));
	c_full: cover property (!DATA_READY);
endmodule

// file: tb/ppp_port_tb.sv
`timescale 1ns/1ps
module ppp_port_tb;
	logic       CLK = 1'b0;
	logic       RST, WR, RD, DATA_READY, IRQ, PD_OE, STROBE, AUTO_LF, INIT_N, SELECT_IN;
	logic       BUSY, ACK_N, PAPER_END, SELECTED, ERROR_N;
	logic [1:0] ADDR;
	logic [7:0] WDATA, RDATA, PD_IN, PD_OUT, pdrv, got;
	logic [2:0] cond;
	logic [1:0] w;
	int         miscompares, comparisons;
	assign w = {IRQ, BUSY};
	always #2.5 CLK = ~CLK;
	ppp_port #(.STROBE_NS(50), .SETUP_NS(50)) ppp_port_i (.CLK(CLK), .RST(RST), .WR(WR),
		.RD(RD), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .DATA_READY(DATA_READY),
		.IRQ(IRQ), .PD_IN(PD_IN), .PD_OUT(PD_OUT), .PD_OE(PD_OE), .STROBE(STROBE),
		.AUTO_LF(AUTO_LF), .INIT_N(INIT_N), .SELECT_IN(SELECT_IN), .BUSY(BUSY),
		.ACK_N(ACK_N), .PAPER_END(PAPER_END), .SELECTED(SELECTED), .ERROR_N(ERROR_N));
	ppp_printer ppp_printer_i (.CLK(CLK), .RST(RST), .STROBE(STROBE), .PD_OE(PD_OE),
		.PD_OUT(PD_OUT), .pdrv(pdrv), .cond(cond), .BUSY(BUSY), .ACK_N(ACK_N),
		.PAPER_END(PAPER_END), .SELECTED(SELECTED), .ERROR_N(ERROR_N), .PD_IN(PD_IN),
		.got(got));
	////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %0t: saw %h want %h", $time, s, e);
		end
	endtask
	// Host write, one cycle
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(negedge CLK);
		{WR, ADDR, WDATA} = {1'b1, a, d};
		@(negedge CLK);
		WR = 1'b0;
	endtask
	// Host read, answer one cycle later
	task rd(input logic [1:0] a, input logic [7:0] e);
		@(negedge CLK);
		{RD, ADDR} = {1'b1, a};
		@(negedge CLK);
		RD = 1'b0;
		chk(RDATA, e);
	endtask
	// Bounded wait on busy (0) or irq (1)
	task wt(input int k, input logic v);
		int n;
		for (n = 0; n < 400 && w[k] !== v; n++)
			@(negedge CLK);
		if (n == 400)
		begin
			miscompares++;
			$display("Error %0t: wait timed out", $time);
			conclude();
		end
	endtask
	task conclude();
		$display("Counts: %0d compared, %0d wrong", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Latches, read-back, direction, unmapped place
	task t_regs();
		wr(2'h0, 8'hA5);
		rd(2'h0, 8'hA5);
		chk(PD_OUT, 8'hA5);
		wr(2'h2, 8'hEE);
		rd(2'h2, 8'h0E);
		chk(8'(PD_OE), 8'h00);
		repeat (3) @(negedge CLK);
		rd(2'h0, 8'h3C);
		chk(8'({SELECT_IN, INIT_N, AUTO_LF}), 8'h07);
		wr(2'h2, 8'h00);
		wr(2'h3, 8'hFF);
		rd(2'h3, 8'h00);
		chk(8'({PD_OE, INIT_N, SELECT_IN}), 8'h04);
		$display("Register test done");
	endtask
	// Every condition pattern on the status byte
	task t_status();
		for (int i = 0; i < 8; i++)
		begin
			cond = 3'(i);
			repeat (4) @(negedge CLK);
			rd(2'h1, {2'b01, cond, 3'h0});
		end
		$display("Status test done");
	endtask
	// Print with irq, fill buffer until refused, drain
	task t_print();
		cond = 3'h3;
		wr(2'h2, 8'h14);
		wr(2'h0, 8'h5A);
		wr(2'h2, 8'h15);
		wr(2'h2, 8'h14);
		wr(2'h0, 8'h11);
		wr(2'h0, 8'h22);
		wr(2'h0, 8'h33);
		chk(8'(DATA_READY), 8'h00);
		wt(0, 1'b1);
		chk(got, 8'h5A);
		repeat (4) @(negedge CLK);
		rd(2'h1, 8'hD8);
		wt(1, 1'b1);
		rd(2'h1, 8'h58);
		chk(8'(IRQ), 8'h00);
		repeat (30) @(negedge CLK);
		chk({DATA_READY, PD_OUT[6:0]}, 8'hA2);
		$display("Print test done");
	endtask
	// Print with irq disabled
	task t_mask();
		wr(2'h2, 8'h04);
		wr(2'h2, 8'h05);
		wr(2'h2, 8'h04);
		wt(0, 1'b1);
		chk(got, 8'h22);
		wt(0, 1'b0);
		repeat (6) @(negedge CLK);
		chk(8'(IRQ), 8'h00);
		$display("Masked print done");
	endtask
	initial
	begin
		{RST, WR, RD, ADDR, WDATA, pdrv, cond} = {3'b100, 2'h0, 8'h00, 8'h3C, 3'h7};
		repeat (2) @(negedge CLK);
		RST = 1'b0;
		t_regs();
		t_status();
		t_print();
		t_mask();
		conclude();
	end
endmodule
bind ppp_port ppp_checker #(.STROBE_NS(STROBE_NS), .SETUP_NS(SETUP_NS)) ppp_checker_i (
	.CLK(CLK), .RST(RST), .WR(WR), .RD(RD), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA),
	.DATA_READY(DATA_READY), .IRQ(IRQ), .PD_OUT(PD_OUT), .PD_OE(PD_OE), .STROBE(STROBE),
	.AUTO_LF(AUTO_LF), .INIT_N(INIT_N), .SELECT_IN(SELECT_IN), .ACK_N(ACK_N));

// file: tb/ppp_printer.sv
`timescale 1ns/1ps
module ppp_printer
#(
	parameter int ACK_CYC = 20
)
(
	// Clock and reset
	input wire logic       CLK,
	input wire logic       RST,
	// From the port
	input wire logic       STROBE,
	input wire logic       PD_OE,
	input wire logic [7:0] PD_OUT,
	// Bench settings
	input wire logic [7:0] pdrv,
	input wire logic [2:0] cond,
	// Toward the port
	output logic           BUSY,
	output logic           ACK_N,
	output logic           PAPER_END,
	output logic           SELECTED,
	output logic           ERROR_N,
	output logic     [7:0] PD_IN,
	output logic     [7:0] got
);
	int cnt; // Cycles since byte taken
	// Condition lines and shared data wire
	assign {PAPER_END, SELECTED, ERROR_N} = cond;
	assign PD_IN = PD_OE ? PD_OUT : pdrv;
	////////////////////////////////////////////////////////////////
	// Take a byte on strobe, acknowledge late in busy
	always_ff @(posedge CLK)
	begin
		if (RST)
			{BUSY, ACK_N, got, cnt} <= {1'b0, 1'b1, 8'h00, 32'h0};
		else if (STROBE && !BUSY)
			{BUSY, got, cnt} <= {1'b1, PD_OUT, 32'h0};
		else if (BUSY)
		begin
			cnt   <= cnt + 1;
			ACK_N <= !(cnt >= ACK_CYC && cnt < 2 * ACK_CYC - 1);
			BUSY  <= cnt < 2 * ACK_CYC - 1;
		end
	end
endmodule
